// ### common/ddrcmd_pkg.sv
// constants and types shared by the ddr command decoder
package ddrcmd_pkg;
  // ---------------------------------------------------------------
  // commands, coded as {ras_n, cas_n, we_n}
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR  = 3'h4,
    CMD_RD  = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } ddrcmd_cmd_t;

  // ---------------------------------------------------------------
  // mode register fields
  // ---------------------------------------------------------------
  localparam int          BL_LSB      = 0;
  localparam logic [2:0]  BL2         = 3'h1;
  localparam logic [2:0]  BL4         = 3'h2;
  localparam logic [2:0]  BL8         = 3'h3;
  localparam int          BT_BIT      = 3;
  localparam int          CL_LSB      = 4;
  localparam logic [2:0]  CL2         = 3'h2;
  localparam logic [2:0]  CL25        = 3'h6;
  localparam logic [2:0]  CL3         = 3'h3;
  localparam int          OPM_LSB     = 7;
  localparam int          DLL_RST_BIT = 8;
  localparam logic [12:0] MR_RESET    = 13'h0032;

  // ---------------------------------------------------------------
  // extended mode register, bank select, address fields
  // ---------------------------------------------------------------
  localparam int          DLL_DIS_BIT = 0;
  localparam int          DRV_BIT     = 1;
  localparam logic [12:0] EMR_RESET   = 13'h0000;
  localparam logic [1:0]  BA_MR       = 2'h0;
  localparam logic [1:0]  BA_EMR      = 2'h1;
  localparam int          AP_BIT      = 10;

  // ---------------------------------------------------------------
  // timing, in link clock cycles
  // ---------------------------------------------------------------
  localparam logic [7:0]  DLL_LOCK_CYC = 8'hC8;  // 200 cycles
endpackage

// ### logic/ddrcmd_decode.sv
// ddr command decoder, burst sequencer and mode registers
`timescale 1ns/1ps
`default_nettype none

module ddrcmd_decode #(
  parameter int ROW_W = 13
) (
  // system clock side
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // command pins, on the link clock
  input  wire logic             lclk,
  input  wire logic             cke,
  input  wire logic             cs_n,
  input  wire logic             ras_n,
  input  wire logic             cas_n,
  input  wire logic             we_n,
  input  wire logic [1:0]       ba,
  input  wire logic [ROW_W-1:0] addr,
  input  wire logic             dm,
  // burst beats, on the link clock
  output var  logic             beat_valid,
  output var  logic             beat_write,
  output var  logic             beat_half,
  output var  logic [1:0]       beat_bank,
  output var  logic [9:0]       beat_col,
  output var  logic             wr_commit,
  // row and refresh events, on the link clock
  output var  logic             act_valid,
  output var  logic [1:0]       act_bank,
  output var  logic [ROW_W-1:0] act_row,
  output var  logic             ref_pulse,
  output var  logic [ROW_W-1:0] ref_row,
  output var  logic             dll_reset_pulse,
  output var  logic             drive_half,
  // status, on the system clock
  output var  logic             sys_dll_ready,
  output var  logic             sys_self_refresh,
  output var  logic [3:0]       sys_bank_open,
  output var  logic             sys_mode_load
);

  // ---------------------------------------------------------------
  // state of both domains
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]       rsync;
    logic [1:0]       csync;
    logic [ROW_W-1:0] mr;
    logic [ROW_W-1:0] emr;
    logic [3:0]       open;
    logic             selfref;
    logic [7:0]       dll_cnt;
    logic             dll_ready;
    logic [ROW_W-1:0] refctr;
    logic             b_act;
    logic             b_wr;
    logic             b_ap;
    logic             b_seq;
    logic             b_half;
    logic [1:0]       b_bank;
    logic [1:0]       b_wait;
    logic [9:0]       b_base;
    logic [2:0]       b_k;
    logic [2:0]       b_mask;
    logic             beat_valid;
    logic             beat_write;
    logic             beat_half;
    logic             beat_first;
    logic             beat_seq;
    logic [2:0]       beat_mask;
    logic [1:0]       beat_bank;
    logic [9:0]       beat_col;
    logic             wr_commit;
    logic             act_valid;
    logic [1:0]       act_bank;
    logic [ROW_W-1:0] act_row;
    logic             ref_pulse;
    logic [ROW_W-1:0] ref_row;
    logic             dll_reset_pulse;
    logic             mode_tgl;
  } ddrcmd_link_t;

  typedef struct packed {
    logic [1:0] dr;
    logic [1:0] sr;
    logic [3:0] bo1;
    logic [3:0] bo2;
    logic [2:0] mt;
    logic       mode_load;
  } ddrcmd_sys_t;

  ddrcmd_link_t s_l;
  ddrcmd_link_t next_l;
  ddrcmd_sys_t  s_m;
  ddrcmd_sys_t  next_m;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // column of beat k inside the aligned block
  function automatic logic [9:0] col_at(input logic [9:0] base,
                                        input logic [2:0] k,
                                        input logic [2:0] mask,
                                        input logic       seq);
    logic [2:0] low;
    low = seq ? 3'(base[2:0] + k) : (base[2:0] ^ k);
    return {base[9:3], (base[2:0] & ~mask) | (low & mask)};
  endfunction

  // start-bit mask for the programmed burst length
  function automatic logic [2:0] len_mask(input logic [2:0] code);
    case (code)
      ddrcmd_pkg::BL4: len_mask = 3'h3;
      ddrcmd_pkg::BL8: len_mask = 3'h7;
      default:         len_mask = 3'h1;
    endcase
  endfunction

  logic                    l_go;
  logic                    l_sel;
  ddrcmd_pkg::ddrcmd_cmd_t l_cmd;
  logic [2:0]              l_cl;

  // deselect, and clock enable low other than the refresh code, fall through as no operation
  assign l_go  = s_l.rsync[1] && s_l.csync[1] && !s_l.selfref;
  assign l_sel = l_go && !cs_n && cke;
  assign l_cmd = ddrcmd_pkg::ddrcmd_cmd_t'({ras_n, cas_n, we_n});
  assign l_cl  = s_l.mr[ddrcmd_pkg::CL_LSB +: 3];

  // ---------------------------------------------------------------
  // link domain
  // ---------------------------------------------------------------
  always_comb begin
    next_l = s_l;
    if (!s_l.rsync[1]) begin
      next_l     = '0;
      next_l.mr  = ddrcmd_pkg::MR_RESET[ROW_W-1:0];
      next_l.emr = ddrcmd_pkg::EMR_RESET[ROW_W-1:0];
    end else if (s_l.csync[1]) begin
      next_l.beat_valid      = 1'b0;
      next_l.wr_commit       = 1'b0;
      next_l.act_valid       = 1'b0;
      next_l.ref_pulse       = 1'b0;
      next_l.dll_reset_pulse = 1'b0;
      // loop lock count, cleared to zero while disabled
      if (s_l.emr[ddrcmd_pkg::DLL_DIS_BIT]) begin
        next_l.dll_ready = 1'b0;
        next_l.dll_cnt   = 8'h00;
      end else if (!s_l.dll_ready) begin
        next_l.dll_cnt = s_l.dll_cnt + 8'h01;
        if (s_l.dll_cnt == ddrcmd_pkg::DLL_LOCK_CYC - 8'h01) begin
          next_l.dll_ready = 1'b1;
        end
      end
      if (s_l.selfref) begin
        // only cke is looked at while refreshing itself
        next_l.dll_ready = 1'b0;
        next_l.dll_cnt   = 8'h00;
        if (cke) begin
          next_l.selfref                         = 1'b0;
          next_l.emr[ddrcmd_pkg::DLL_DIS_BIT]    = 1'b0;
        end
      end else begin
        // burst sequencer, one element per link cycle
        if (s_l.b_act) begin
          if (s_l.b_wait != 2'h0) begin
            next_l.b_wait = s_l.b_wait - 2'h1;
          end else begin
            next_l.beat_valid = 1'b1;
            next_l.beat_write = s_l.b_wr;
            next_l.beat_half  = s_l.b_half;
            next_l.beat_bank  = s_l.b_bank;
            next_l.beat_first = (s_l.b_k == 3'h0);
            next_l.beat_seq   = s_l.b_seq;
            next_l.beat_mask  = s_l.b_mask;
            next_l.beat_col   = col_at(s_l.b_base, s_l.b_k, s_l.b_mask, s_l.b_seq);
            next_l.wr_commit  = s_l.b_wr && !dm;
            next_l.b_k        = s_l.b_k + 3'h1;
            if (s_l.b_k == s_l.b_mask) begin
              next_l.b_act = 1'b0;
              if (s_l.b_ap) begin
                next_l.open[s_l.b_bank] = 1'b0;
              end
            end
          end
        end
        // refresh code with cke low enters self refresh
        if (l_go && !cs_n && !cke && l_cmd == ddrcmd_pkg::CMD_REF) begin
          next_l.selfref = 1'b1;
          next_l.b_act   = 1'b0;
        end
        if (l_sel) begin
          unique case (l_cmd)
            ddrcmd_pkg::CMD_MRS: begin
              if (ba == ddrcmd_pkg::BA_MR) begin
                next_l.mr                          = addr;
                next_l.mr[ddrcmd_pkg::DLL_RST_BIT] = 1'b0;
                next_l.mode_tgl                    = !s_l.mode_tgl;
                if (addr[ddrcmd_pkg::DLL_RST_BIT] && !addr[ddrcmd_pkg::OPM_LSB]
                    && addr[ROW_W-1:9] == '0) begin
                  next_l.dll_reset_pulse = 1'b1;
                  next_l.dll_ready       = 1'b0;
                  next_l.dll_cnt         = 8'h00;
                end
              end else if (ba == ddrcmd_pkg::BA_EMR) begin
                next_l.emr      = addr;
                next_l.mode_tgl = !s_l.mode_tgl;
                if (!addr[ddrcmd_pkg::DLL_DIS_BIT]) begin
                  next_l.dll_ready = 1'b0;
                  next_l.dll_cnt   = 8'h00;
                end
              end
            end
            ddrcmd_pkg::CMD_REF: begin
              next_l.ref_pulse = 1'b1;
              next_l.ref_row   = s_l.refctr;
              next_l.refctr    = ROW_W'(s_l.refctr + 1'b1);
            end
            ddrcmd_pkg::CMD_PRE: begin
              if (addr[ddrcmd_pkg::AP_BIT]) begin
                next_l.open = 4'h0;
              end else begin
                next_l.open[ba] = 1'b0;
              end
            end
            ddrcmd_pkg::CMD_ACT: begin
              next_l.open[ba]  = 1'b1;
              next_l.act_valid = 1'b1;
              next_l.act_bank  = ba;
              next_l.act_row   = addr;
            end
            ddrcmd_pkg::CMD_WR, ddrcmd_pkg::CMD_RD: begin
              next_l.b_act  = 1'b1;
              next_l.b_wr   = (l_cmd == ddrcmd_pkg::CMD_WR);
              next_l.b_ap   = addr[ddrcmd_pkg::AP_BIT];
              next_l.b_bank = ba;
              next_l.b_base = addr[9:0];
              next_l.b_k    = 3'h0;
              next_l.b_mask = len_mask(s_l.mr[ddrcmd_pkg::BL_LSB +: 3]);
              next_l.b_seq  = !s_l.mr[ddrcmd_pkg::BT_BIT];
              next_l.b_half = (l_cmd == ddrcmd_pkg::CMD_RD) && (l_cl == ddrcmd_pkg::CL25);
              next_l.b_wait = 2'h0;
              if (l_cmd == ddrcmd_pkg::CMD_RD) begin
                next_l.b_wait = (l_cl == ddrcmd_pkg::CL2) ? 2'h1 : 2'h2;
              end
            end
            ddrcmd_pkg::CMD_BST: begin
              if (s_l.b_act && !s_l.b_wr && !s_l.b_ap) begin
                next_l.b_act = 1'b0;
              end
            end
            ddrcmd_pkg::CMD_NOP: begin
              next_l.b_k = next_l.b_k;
            end
          endcase
        end
      end
    end
    next_l.rsync = {s_l.rsync[0], rst_n};
    next_l.csync = {s_l.csync[0], ce};
  end

  // link state register
  always_ff @(posedge lclk) begin
    s_l <= next_l;
  end

  // ---------------------------------------------------------------
  // system domain: status brought over by level synchronisers
  // ---------------------------------------------------------------
  always_comb begin
    next_m = s_m;
    if (!rst_n) begin
      next_m = '0;
    end else if (ce) begin
      next_m.dr        = {s_m.dr[0], s_l.dll_ready};
      next_m.sr        = {s_m.sr[0], s_l.selfref};
      next_m.bo1       = s_l.open;
      next_m.bo2       = s_m.bo1;
      next_m.mt        = {s_m.mt[1:0], s_l.mode_tgl};
      next_m.mode_load = s_m.mt[2] ^ s_m.mt[1];
    end
  end

  // system state register
  always_ff @(posedge mclk) begin
    s_m <= next_m;
  end

  // outputs straight from flops
  assign beat_valid       = s_l.beat_valid;
  assign beat_write       = s_l.beat_write;
  assign beat_half        = s_l.beat_half;
  assign beat_bank        = s_l.beat_bank;
  assign beat_col         = s_l.beat_col;
  assign wr_commit        = s_l.wr_commit;
  assign act_valid        = s_l.act_valid;
  assign act_bank         = s_l.act_bank;
  assign act_row          = s_l.act_row;
  assign ref_pulse        = s_l.ref_pulse;
  assign ref_row          = s_l.ref_row;
  assign dll_reset_pulse  = s_l.dll_reset_pulse;
  assign drive_half       = s_l.emr[ddrcmd_pkg::DRV_BIT];
  assign sys_dll_ready    = s_m.dr[1];
  assign sys_self_refresh = s_m.sr[1];
  assign sys_bank_open    = s_m.bo2;
  assign sys_mode_load    = s_m.mode_load;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic l_quiet;
  assign l_quiet = !l_sel && cke && s_l.csync[1] && s_l.rsync[1];

  // write data starts one cycle on at its start column
  property p_wr_first;
    @(posedge lclk) disable iff (!s_l.rsync[1])
    (l_sel && l_cmd == ddrcmd_pkg::CMD_WR) ##1 l_quiet
    |=> (beat_valid && beat_write && s_l.beat_first && beat_col == $past(addr[9:0], 2));
  endproperty
  a_wr_first: assert property (p_wr_first) else $error("write burst start wrong");

  // read at latency three: first beat after edge n+3
  property p_rd_cl3;
    @(posedge lclk) disable iff (!s_l.rsync[1])
    (l_sel && l_cmd == ddrcmd_pkg::CMD_RD && l_cl == ddrcmd_pkg::CL3) ##1 l_quiet [*3]
    |=> (beat_valid && !beat_write && s_l.beat_first);
  endproperty
  a_rd_cl3: assert property (p_rd_cl3) else $error("read latency wrong");

  // later beats stay in the same aligned block
  property p_block;
    @(posedge lclk) disable iff (!s_l.rsync[1])
    (beat_valid && !s_l.beat_first && $past(beat_valid) && $past(s_l.csync[1]))
    |-> (beat_col[9:3] == $past(beat_col[9:3])
         && ((beat_col[2:0] ^ $past(beat_col[2:0])) & ~s_l.beat_mask) == 3'h0);
  endproperty
  a_block: assert property (p_block) else $error("burst left its block");

  // sequential beats step by one and wrap
  property p_seq_step;
    @(posedge lclk) disable iff (!s_l.rsync[1])
    (beat_valid && s_l.beat_seq && !s_l.beat_first && $past(beat_valid)
     && $past(s_l.csync[1]))
    |-> (((beat_col[2:0] ^ 3'($past(beat_col[2:0]) + 3'h1)) & s_l.beat_mask) == 3'h0);
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("sequential order wrong");

  // interleaved second beat flips only bit 0
  property p_intlv;
    @(posedge lclk) disable iff (!s_l.rsync[1])
    (beat_valid && !s_l.beat_seq && !s_l.beat_first && $past(s_l.beat_first)
     && $past(beat_valid) && $past(s_l.csync[1]))
    |-> (beat_col == ($past(beat_col) ^ 10'h001));
  endproperty
  a_intlv: assert property (p_intlv) else $error("interleaved order wrong");

  // loop reset pattern pulses and drops readiness
  property p_dll_rst;
    @(posedge lclk) disable iff (!s_l.rsync[1])
    (l_sel && l_cmd == ddrcmd_pkg::CMD_MRS && ba == ddrcmd_pkg::BA_MR
     && addr[ddrcmd_pkg::DLL_RST_BIT] && !addr[ddrcmd_pkg::OPM_LSB] && addr[ROW_W-1:9] == '0)
    |=> (dll_reset_pulse && !s_l.dll_ready && !s_l.mr[ddrcmd_pkg::DLL_RST_BIT]);
  endproperty
  a_dll_rst: assert property (p_dll_rst) else $error("loop reset missed");

  // extended register takes the op-code
  property p_emr;
    @(posedge lclk) disable iff (!s_l.rsync[1])
    (l_sel && l_cmd == ddrcmd_pkg::CMD_MRS && ba == ddrcmd_pkg::BA_EMR)
    |=> (s_l.emr == $past(addr) && $stable(s_l.mr));
  endproperty
  a_emr: assert property (p_emr) else $error("extended load wrong");

  // leaving self refresh re-enables the loop
  property p_srexit;
    @(posedge lclk) disable iff (!s_l.rsync[1])
    (s_l.selfref && cke && s_l.csync[1])
    |=> (!s_l.selfref && !s_l.emr[ddrcmd_pkg::DLL_DIS_BIT] && !s_l.dll_ready);
  endproperty
  a_srexit: assert property (p_srexit) else $error("self refresh exit wrong");

  // precharge all closes every bank
  property p_pre_all;
    @(posedge lclk) disable iff (!s_l.rsync[1])
    (l_sel && l_cmd == ddrcmd_pkg::CMD_PRE && addr[ddrcmd_pkg::AP_BIT]) |=> (s_l.open == 4'h0);
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all failed");

  // deselect starts nothing
  property p_desel;
    @(posedge lclk) disable iff (!s_l.rsync[1])
    (cs_n && s_l.csync[1]) |=> !(act_valid || ref_pulse || dll_reset_pulse);
  endproperty
  a_desel: assert property (p_desel) else $error("deselect acted");

  // mask high stops the element being written
  property p_mask;
    @(posedge lclk) disable iff (!s_l.rsync[1])
    (beat_valid && $past(s_l.csync[1])) |-> (wr_commit == (beat_write && !$past(dm)));
  endproperty
  a_mask: assert property (p_mask) else $error("write mask ignored");

  c_rd_burst: cover property (@(posedge lclk) disable iff (!s_l.rsync[1])
    beat_valid && !beat_write && s_l.beat_mask == 3'h7);
  c_selfref: cover property (@(posedge lclk) disable iff (!s_l.rsync[1])
    s_l.selfref ##1 !s_l.selfref);
  c_dll_lock: cover property (@(posedge lclk) disable iff (!s_l.rsync[1])
    $rose(s_l.dll_ready));

endmodule  // ddrcmd_decode

`default_nettype wire

// ### tb/ddrcmd_ctrl_model.sv
// controller model that drives the link command pins
`timescale 1ns/1ps
`default_nettype none
module ddrcmd_ctrl_model (
  // link clock
  input  wire logic        lclk,
  // command pins, cmd is {ras_n, cas_n, we_n}
  output var  logic        cke,
  output var  logic        cs_n,
  output var  logic [2:0]  cmd,
  output var  logic [1:0]  ba,
  output var  logic [12:0] addr,
  output var  logic        dm
);
  realtime t_cmd;  // edge that took the last command

  // idle pins: deselected, clock enabled
  initial begin
    {cke, cs_n, cmd, ba, addr, dm} = {2'h3, 3'h7, 2'h0, 13'h0, 1'b0};
  end

  // one whole command, then deselect with released lines inverted
  // never overlaps a burst and never terminates one
  task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
                       input logic [7:0] m, input logic sel_n, input logic en);
    @(posedge lclk);
    {cke, cs_n, cmd, ba, addr} <= {en, sel_n, c, b, a};
    @(posedge lclk);
    t_cmd = $realtime;
    {cke, cs_n, cmd, ba, addr} <= {en, 1'b1, ~c, ~b, ~a};
    // one mask bit ahead of each beat edge
    for (int i = 0; i < 8; i++) begin
      dm <= m[i];
      @(posedge lclk);
    end
    dm <= ~m[7];
  endtask
endmodule // ddrcmd_ctrl_model
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the ddr command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ---------------------------------------------------------------
  // clocks, pins, bookkeeping
  // ---------------------------------------------------------------
  logic        mclk = 1'b0;
  logic        lclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  wire logic   cke, cs_n, dm;
  wire logic [2:0]  cmd;
  wire logic [1:0]  ba;
  wire logic [12:0] addr;
  logic        beat_valid, beat_write, beat_half, wr_commit, act_valid, ref_pulse;
  logic        dll_reset_pulse, drive_half, sys_dll_ready, sys_self_refresh, sys_mode_load;
  logic [1:0]  beat_bank, act_bank;
  logic [9:0]  beat_col;
  logic [12:0] act_row, ref_row;
  logic [3:0]  sys_bank_open;
  logic [14:0] last_act, bq[$];
  realtime     tq[$];
  int          fail_count = 0, checks = 0, seed = 32'h280d;
  int          n_act = 0, n_ref = 0, n_dll = 0, n_mode = 0;
  logic [2:0]  cbl = ddrcmd_pkg::BL4, ccl = ddrcmd_pkg::CL3;
  logic        cbt = 1'b0;
  logic [2:0]  bls[3] = '{ddrcmd_pkg::BL2, ddrcmd_pkg::BL4, ddrcmd_pkg::BL8};
  logic [2:0]  cls[3] = '{ddrcmd_pkg::CL2, ddrcmd_pkg::CL25, ddrcmd_pkg::CL3};

  always #12.5 mclk = ~mclk;
  always #80 lclk = ~lclk;

  ddrcmd_ctrl_model ctrl (.lclk, .cke, .cs_n, .cmd, .ba, .addr, .dm);
  ddrcmd_decode #(.ROW_W(13)) DUT (
    .mclk, .rst_n, .ce, .lclk, .cke, .cs_n, .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]),
    .ba, .addr, .dm, .beat_valid, .beat_write, .beat_half, .beat_bank, .beat_col,
    .wr_commit, .act_valid, .act_bank, .act_row, .ref_pulse, .ref_row, .dll_reset_pulse,
    .drive_half, .sys_dll_ready, .sys_self_refresh, .sys_bank_open, .sys_mode_load);

  // collect link events and status pulses
  always @(posedge lclk) begin
    if (beat_valid === 1'b1) begin
      bq.push_back({beat_write, beat_half, wr_commit, beat_bank, beat_col});
      tq.push_back($realtime);
    end
    if (act_valid === 1'b1) begin
      n_act++;
      last_act = {act_bank, act_row};
    end
    if (ref_pulse === 1'b1) n_ref++;
    if (dll_reset_pulse === 1'b1) n_dll++;
  end
  always @(posedge mclk) if (sys_mode_load === 1'b1) n_mode++;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // column of beat k: wraps inside the aligned block
  function automatic logic [9:0] exp_col(logic [9:0] c, logic [2:0] msk, int k, logic bt);
    logic [2:0] lo;
    lo = bt ? (c[2:0] ^ 3'(k)) : (c[2:0] + 3'(k));
    return (c & ~{7'h0, msk}) | {7'h0, lo & msk};
  endfunction

  task automatic wait_ready();
    for (int i = 0; i < 4000; i++) begin
      @(posedge mclk);
      if (sys_dll_ready === 1'b1) return;
    end
    $display("mismatch at %0t: loop never ready", $time);
    fail_count++;
    close_out();
  endtask

  // burst length, type and latency as given, operating mode zero or loop reset
  task automatic load_mode(input logic [2:0] bl, input logic bt, input logic [2:0] cl,
                           input logic dll);
    {cbl, cbt, ccl} = {bl, bt, cl};
    ctrl.issue(ddrcmd_pkg::CMD_MRS, ddrcmd_pkg::BA_MR, {4'h0, dll, 1'b0, cl, bt, bl},
               8'h0, 1'b0, 1'b1);
  endtask

  // one read or write burst in the current mode, random bank, mask, precharge
  task automatic burst(input logic wr, input logic [9:0] c);
    logic [2:0] msk;
    logic [7:0] m;
    logic [1:0] b;
    int lat;
    msk = (cbl == ddrcmd_pkg::BL8) ? 3'h7 : (cbl == ddrcmd_pkg::BL4) ? 3'h3 : 3'h1;
    lat = wr ? 2 : (ccl == ddrcmd_pkg::CL2) ? 3 : 4;
    m = 8'($random(seed));
    b = 2'($random(seed));
    bq.delete();
    tq.delete();
    ctrl.issue(wr ? ddrcmd_pkg::CMD_WR : ddrcmd_pkg::CMD_RD, b, {2'h0, m[7], c}, m, 1'b0, 1'b1);
    repeat (4) @(posedge lclk);
    check(bq.size(), msk + 1, "beat count");
    for (int k = 0; k < bq.size(); k++) begin
      check(bq[k][9:0], exp_col(c, msk, k, cbt), "column");
      check({bq[k][14], bq[k][13], bq[k][12:10]},
            {wr, ~wr & (ccl == ddrcmd_pkg::CL25), wr & ~m[k], b}, "beat flags");
      check($rtoi((tq[k] - ctrl.t_cmd) / 160.0), lat + k, "beat time");
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [12:0] r;
    repeat (24) @(posedge mclk);
    check({sys_bank_open, sys_self_refresh, sys_dll_ready, drive_half}, 7'h0, "reset");
    rst_n <= 1'b1;
    wait_ready();
    burst(1'b0, 10'h3FE);
    for (int i = 0; i < 18; i++) begin
      load_mode(bls[i % 3], 1'(i / 9), cls[(i / 3) % 3], 1'b0);
      burst(1'($random(seed)), 10'($random(seed)));
      burst(1'($random(seed)), 10'($random(seed)));
    end
    burst(1'b0, 10'h003);
    ctrl.issue(ddrcmd_pkg::CMD_MRS, 2'h2, 13'h0021, 8'h0, 1'b0, 1'b1);
    burst(1'b1, 10'h3FD);
    ctrl.issue(ddrcmd_pkg::CMD_MRS, ddrcmd_pkg::BA_EMR, 13'h0002, 8'h0, 1'b0, 1'b1);
    check(drive_half, 1'b1, "drive strength");
    load_mode(cbl, cbt, ccl, 1'b1);
    check(n_dll, 1, "loop reset pulse");
    load_mode(cbl, cbt, ccl, 1'b0);
    wait_ready();
    check(drive_half, 1'b1, "drive kept");
    burst(1'b0, 10'h155);
    check(n_mode, 21, "mode loads");
    for (int i = 0; i < 4; i++) begin
      r = 13'($random(seed));
      ctrl.issue(ddrcmd_pkg::CMD_ACT, 2'(i), r, 8'h0, 1'b0, 1'b1);
      check(last_act, {2'(i), r}, "activate");
    end
    check(sys_bank_open, 4'hF, "banks open");
    // write with bit 10 high closes its bank after the last element
    ctrl.issue(ddrcmd_pkg::CMD_WR, 2'h3, 13'h0400, 8'h0, 1'b0, 1'b1);
    repeat (2) @(posedge lclk);
    check(sys_bank_open, 4'h7, "auto precharge closes");
    ctrl.issue(ddrcmd_pkg::CMD_PRE, 2'h2, 13'h0BFF, 8'h0, 1'b0, 1'b1);
    check(sys_bank_open, 4'h3, "one bank closed");
    ctrl.issue(ddrcmd_pkg::CMD_PRE, 2'h1, 13'h0400, 8'h0, 1'b0, 1'b1);
    check(sys_bank_open, 4'h0, "all banks closed");
    // clock enable low freezes the block: a command is dropped
    @(posedge mclk);
    ce <= 1'b0;
    repeat (2) @(posedge lclk);
    ctrl.issue(ddrcmd_pkg::CMD_ACT, 2'h1, 13'h0, 8'h0, 1'b0, 1'b1);
    check({sys_bank_open, 4'(n_act)}, 8'h04, "frozen drops command");
    @(posedge mclk);
    ce <= 1'b1;
    repeat (3) @(posedge lclk);
    bq.delete();
    for (int i = 0; i < 8; i++) ctrl.issue(3'(i), 2'(i), 13'h1FFF, 8'hFF, 1'b1, 1'b1);
    ctrl.issue(ddrcmd_pkg::CMD_NOP, 2'h0, 13'h0, 8'h0, 1'b0, 1'b1);
    ctrl.issue(ddrcmd_pkg::CMD_BST, 2'h0, 13'h0, 8'h0, 1'b0, 1'b1);
    check(bq.size() + n_act + n_dll + n_ref + n_mode, 26, "deselect inert");
    ctrl.issue(ddrcmd_pkg::CMD_REF, 2'h3, 13'h1234, 8'h0, 1'b0, 1'b1);
    check(n_ref, 1, "auto refresh");
    check(ref_row, 13'h0000, "refresh row from counter");
    ctrl.issue(ddrcmd_pkg::CMD_REF, 2'h0, 13'h0, 8'h0, 1'b0, 1'b0);
    ctrl.issue(ddrcmd_pkg::CMD_ACT, 2'h0, 13'h0, 8'h0, 1'b0, 1'b0);
    check({sys_self_refresh, sys_dll_ready}, 2'h2, "in self refresh");
    ctrl.issue(ddrcmd_pkg::CMD_NOP, 2'h0, 13'h0, 8'h0, 1'b0, 1'b1);
    wait_ready();
    check({sys_self_refresh, 4'(n_act), 4'(n_ref)}, 9'h041, "refresh exit");
    burst(1'b1, 10'h2A7);
    close_out();
  end
endmodule // tb_top
`default_nettype wire
